// file: hw/mfic_pkg.sv
// package: constants and types for the multi-function interrupt controller
package mfic_pkg;

  // ***************************************
  // widths
  // ***************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PC_W   = 13;

  // ***************************************
  // register offsets
  // ***************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_MF0  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_MF1  = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_MF2  = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STAT = 3'h4;

  // ***************************************
  // field positions, masks, reset values
  // ***************************************
  localparam int CTRL_GIE_BIT     = 0;
  localparam int CTRL_OWN_EN_LSB  = 1;
  localparam int CTRL_OWN_FLG_LSB = 4;
  localparam int STAT_FULL_BIT    = 3;
  localparam int STAT_PEND_BIT    = 4;
  localparam int MF_FLAG_LSB      = 4;
  localparam logic [DATA_W-1:0] MF2_IMPL_MASK = 8'h33;
  localparam logic [DATA_W-1:0] REG_RESET     = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET      = 13'h0000;

  // ***************************************
  // types
  // ***************************************
  typedef enum logic [2:0] {
    MFIC_SEL_NONE,
    MFIC_SEL_OWN0,
    MFIC_SEL_OWN1,
    MFIC_SEL_MF0,
    MFIC_SEL_MF1,
    MFIC_SEL_MF2
  } mfic_sel_t;

  // event pulses; bit order of each nibble matches the flag nibble
  typedef struct packed {
    logic [1:0] own_hit;    // own-vector sources
    logic       datamem_done;
    logic       lowvolt_hit;
    logic [3:0] tgrp1_hit;  // ptimer2 a, p, ptimer1 a, p
    logic [3:0] tgrp0_hit;  // ptimer0 a, p, stdtimer a, p
  } mfic_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } mfic_bus_t;

  typedef struct packed {
    logic            take;
    logic [PC_W-1:0] vector;
    logic [PC_W-1:0] push_data;
    logic            push;
    logic            pop;
  } mfic_core_t;

  typedef struct packed {
    logic              gie;
    logic [1:0]        own_en;
    logic [1:0]        own_flag;
    logic [DATA_W-1:0] timer_group0_irq_flags_enables;
    logic [DATA_W-1:0] timer_group1_irq_flags_enables;
    logic [DATA_W-1:0] memory_voltage_irq_flags_enables;
    logic [DATA_W-1:0] rdata;
    mfic_core_t        core;
    mfic_sel_t         last_sel;
    logic              wake;
  } mfic_state_t;

endpackage

// file: hw/mfic_top.sv
// multi-function interrupt controller: flags, enables, priority, vectoring
// Function
// - reg0 flags: ptimer0 a/p, stdtimer a/p
// - reg0 low nibble: matching per-source enables
// - reg1 flags: ptimer2 a/p, ptimer1 a/p
// - reg1 low nibble: matching enables, 1 enables
// - reg2 flags: datamem bit5, lowvolt bit4
// - reg2 enables: datamem bit1, lowvolt bit0
// - reg2 unused bits read zero
// - events set flags regardless of enable
// - disabled pending flag: no branch, stays set
// - global enable low blocks every interrupt
// - take: push next pc, load vector
// - return pops saved pc from stack
// - own vectors; multi-function sources share vectors
// - servicing clears global enable, no nesting
// - blocked requests keep their flags
// - full stack blocks all acknowledgement
// - simultaneous requests use fixed priority
// - any flag set wakes from sleep; here only an event setting a clear flag wakes
// - own-vector service clears its flag
// - global enable: one bit, 1 enables
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module mfic_top
  import mfic_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_OWN0 = 13'h0004,
  parameter logic [PC_W-1:0] VEC_OWN1 = 13'h0008,
  parameter logic [PC_W-1:0] VEC_MF0  = 13'h000c,
  parameter logic [PC_W-1:0] VEC_MF1  = 13'h0010,
  parameter logic [PC_W-1:0] VEC_MF2  = 13'h0014
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire mfic_bus_t         bus,
  output var  logic [DATA_W-1:0] rdata,
  input  wire mfic_events_t      events,
  input  wire logic              instr_boundary,
  input  wire logic [PC_W-1:0]   next_pc,
  input  wire logic              stack_full,
  input  wire logic              return_from_interrupt,
  output var  mfic_core_t        core,
  output var  logic              wake
);

  // ***************************************
  // state
  // ***************************************
  mfic_state_t st;
  mfic_state_t next_st;

  logic [11:0]       flag_now;
  logic [11:0]       event_now;
  logic [11:0]       wake_bits;
  logic [2:0]        mf_req;
  logic [1:0]        own_req;
  logic              any_req;
  logic              accept;
  mfic_sel_t         sel;
  logic [PC_W-1:0]   sel_vec;

  // ***************************************
  // request evaluation
  // ***************************************
  assign flag_now = {st.own_flag,
                     st.memory_voltage_irq_flags_enables[5:4],
                     st.timer_group1_irq_flags_enables[7:4],
                     st.timer_group0_irq_flags_enables[7:4]};
  assign event_now = {events.own_hit, events.datamem_done, events.lowvolt_hit,
                      events.tgrp1_hit, events.tgrp0_hit};

  // only a flag going from clear to set wakes; a preset flag stays quiet
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_wake
      assign wake_bits[gi] = event_now[gi] & ~flag_now[gi];
    end
  endgenerate

  assign mf_req[0] = |(st.timer_group0_irq_flags_enables[7:4]
                       & st.timer_group0_irq_flags_enables[3:0]);
  assign mf_req[1] = |(st.timer_group1_irq_flags_enables[7:4]
                       & st.timer_group1_irq_flags_enables[3:0]);
  assign mf_req[2] = |(st.memory_voltage_irq_flags_enables[5:4]
                       & st.memory_voltage_irq_flags_enables[1:0]);
  assign own_req   = st.own_flag & st.own_en;
  assign any_req   = |{own_req, mf_req};

  // boundary only, global enable set, room on the stack
  assign accept = instr_boundary & st.gie & ~stack_full & any_req;

  // fixed priority: own0, own1, mf0, mf1, mf2
  always_comb begin
    sel     = MFIC_SEL_NONE;
    sel_vec = PC_RESET;
    if (own_req[0]) begin
      sel     = MFIC_SEL_OWN0;
      sel_vec = VEC_OWN0;
    end else if (own_req[1]) begin
      sel     = MFIC_SEL_OWN1;
      sel_vec = VEC_OWN1;
    end else if (mf_req[0]) begin
      sel     = MFIC_SEL_MF0;
      sel_vec = VEC_MF0;
    end else if (mf_req[1]) begin
      sel     = MFIC_SEL_MF1;
      sel_vec = VEC_MF1;
    end else if (mf_req[2]) begin
      sel     = MFIC_SEL_MF2;
      sel_vec = VEC_MF2;
    end
  end

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    next_st            = st;
    next_st.rdata      = REG_RESET;
    next_st.core.take  = 1'b0;
    next_st.core.push  = 1'b0;
    next_st.core.pop   = return_from_interrupt;
    next_st.wake       = |wake_bits;

    // software writes first; hardware sets and clears override below
    if (bus.wr) begin
      if (bus.addr == OFS_CTRL) begin
        next_st.gie      = bus.wdata[CTRL_GIE_BIT];
        next_st.own_en   = bus.wdata[CTRL_OWN_EN_LSB +: 2];
        next_st.own_flag = bus.wdata[CTRL_OWN_FLG_LSB +: 2];
      end else if (bus.addr == OFS_MF0) begin
        next_st.timer_group0_irq_flags_enables = bus.wdata;
      end else if (bus.addr == OFS_MF1) begin
        next_st.timer_group1_irq_flags_enables = bus.wdata;
      end else if (bus.addr == OFS_MF2) begin
        next_st.memory_voltage_irq_flags_enables = bus.wdata & MF2_IMPL_MASK;
      end
    end

    if (bus.rd) begin
      if (bus.addr == OFS_CTRL) begin
        next_st.rdata[CTRL_GIE_BIT]           = st.gie;
        next_st.rdata[CTRL_OWN_EN_LSB +: 2]   = st.own_en;
        next_st.rdata[CTRL_OWN_FLG_LSB +: 2]  = st.own_flag;
      end else if (bus.addr == OFS_MF0) begin
        next_st.rdata = st.timer_group0_irq_flags_enables;
      end else if (bus.addr == OFS_MF1) begin
        next_st.rdata = st.timer_group1_irq_flags_enables;
      end else if (bus.addr == OFS_MF2) begin
        next_st.rdata = st.memory_voltage_irq_flags_enables & MF2_IMPL_MASK;
      end else if (bus.addr == OFS_STAT) begin
        next_st.rdata[2:0]           = st.last_sel;
        next_st.rdata[STAT_FULL_BIT] = stack_full;
        next_st.rdata[STAT_PEND_BIT] = any_req;
      end
    end

    // service: push, vector, drop global enable
    if (accept) begin
      next_st.core.take      = 1'b1;
      next_st.core.push      = 1'b1;
      next_st.core.push_data = next_pc;
      next_st.core.vector    = sel_vec;
      next_st.last_sel       = sel;
      next_st.gie            = 1'b0;
      if (sel == MFIC_SEL_OWN0) begin
        next_st.own_flag[0] = 1'b0;
      end else if (sel == MFIC_SEL_OWN1) begin
        next_st.own_flag[1] = 1'b0;
      end
    end

    // events set flags whatever the enables; a set beats any clear
    next_st.timer_group0_irq_flags_enables[7:4] =
      next_st.timer_group0_irq_flags_enables[7:4] | events.tgrp0_hit;
    next_st.timer_group1_irq_flags_enables[7:4] =
      next_st.timer_group1_irq_flags_enables[7:4] | events.tgrp1_hit;
    next_st.memory_voltage_irq_flags_enables[5] =
      next_st.memory_voltage_irq_flags_enables[5] | events.datamem_done;
    next_st.memory_voltage_irq_flags_enables[4] =
      next_st.memory_voltage_irq_flags_enables[4] | events.lowvolt_hit;
    next_st.own_flag = next_st.own_flag | events.own_hit;
  end

  // ***************************************
  // registers
  // ***************************************
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign core  = st.core;
  assign wake  = st.wake;

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_take_needs_gie: assert property (core.take |-> $past(st.gie))
    else $error("interrupt taken with global enable low");
  a_take_stack_room: assert property (core.take |-> !$past(stack_full))
    else $error("interrupt taken with stack full");
  a_take_boundary: assert property (core.take |-> $past(instr_boundary))
    else $error("interrupt taken off a boundary");
  a_gie_clears: assert property (core.take |-> !st.gie)
    else $error("global enable survived a take");
  a_push_pc: assert property (
    (accept ##1 1'b1) |-> (core.push && core.push_data == $past(next_pc)))
    else $error("pushed pc does not match next pc");
  a_event_sets: assert property (
    events.lowvolt_hit |=> st.memory_voltage_irq_flags_enables[4])
    else $error("low-voltage event lost");
  a_disabled_holds: assert property (
    (st.timer_group0_irq_flags_enables[7] && !st.timer_group0_irq_flags_enables[3]
     && !bus.wr) |=> st.timer_group0_irq_flags_enables[7])
    else $error("disabled flag dropped");
  a_mf2_unused: assert property (
    (bus.rd && bus.addr == OFS_MF2) |=> (rdata & ~MF2_IMPL_MASK) == 8'h00)
    else $error("unused bits read nonzero");
  a_prio_own0: assert property (
    (accept && own_req[0]) |=> core.vector == VEC_OWN0)
    else $error("priority order broken");
  a_own_clear: assert property (
    (accept && sel == MFIC_SEL_OWN1 && !events.own_hit[1]) |=> !st.own_flag[1])
    else $error("own-vector flag not cleared on service");
  a_pop_follows: assert property (return_from_interrupt |=> core.pop)
    else $error("return did not pop");
  a_wake_new: assert property ((events.datamem_done && !flag_now[9]) |=> wake)
    else $error("no wake on new flag");

  // ***************************************
  // assertions: service gating
  // ***************************************
  a_gie_blocks: assert property (
    !st.gie
    |=> !core.take)
    else $error("take while global enable low");
  a_full_blocks: assert property (
    stack_full
    |=> !core.take)
    else $error("take while stack full");
  a_boundary_only: assert property (
    !instr_boundary
    |=> !core.take)
    else $error("take between boundaries");
  a_no_req_idle: assert property (
    !any_req
    |=> !core.take)
    else $error("take with no enabled request");
  a_take_single: assert property (
    core.take
    |=> !core.take)
    else $error("back to back takes");
  a_push_is_take: assert property (
    core.push
    == core.take)
    else $error("push and take out of step");
  a_pop_needs_return_from_interrupt: assert property (
    core.pop
    |-> $past(return_from_interrupt))
    else $error("pop without return");
  a_vector_holds: assert property (
    !core.take
    |-> ($stable(core.vector) && $stable(core.push_data)))
    else $error("vector moved without a take");
  a_vec_mf0: assert property (
    (accept && sel == MFIC_SEL_MF0)
    |=> core.vector == VEC_MF0)
    else $error("shared vector wrong");
  a_own_kept: assert property (
    (!st.gie && st.own_flag[0] && !bus.wr)
    |=> st.own_flag[0])
    else $error("blocked request lost");
  a_own0_clear: assert property (
    (accept && sel == MFIC_SEL_OWN0 && !events.own_hit[0])
    |=> !st.own_flag[0])
    else $error("own flag kept after service");

  // ***************************************
  // assertions: register map and flags
  // ***************************************
  a_ctrl_write: assert property (
    (bus.wr && bus.addr == OFS_CTRL && !accept)
    |=> st.gie == $past(bus.wdata[CTRL_GIE_BIT]))
    else $error("global enable write lost");
  a_gie_reads: assert property (
    (bus.rd && bus.addr == OFS_CTRL)
    |=> rdata[CTRL_GIE_BIT] == $past(st.gie))
    else $error("global enable reads wrong");
  a_mf0_readback: assert property (
    (bus.rd && bus.addr == OFS_MF0)
    |=> rdata == $past(st.timer_group0_irq_flags_enables))
    else $error("group 0 reads wrong");
  a_mf1_readback: assert property (
    (bus.rd && bus.addr == OFS_MF1)
    |=> rdata == $past(st.timer_group1_irq_flags_enables))
    else $error("group 1 reads wrong");
  a_mf2_enables: assert property (
    (bus.wr && bus.addr == OFS_MF2)
    |=> st.memory_voltage_irq_flags_enables[1:0] == $past(bus.wdata[1:0]))
    else $error("memory or voltage enable write lost");
  a_mf2_write_mask: assert property (
    (bus.wr && bus.addr == OFS_MF2)
    |=> (st.memory_voltage_irq_flags_enables & ~MF2_IMPL_MASK) == 8'h00)
    else $error("unused bits stored");
  a_datamem_sets: assert property (
    events.datamem_done
    |=> st.memory_voltage_irq_flags_enables[5])
    else $error("data memory event lost");
  a_tgrp0_sets: assert property (
    events.tgrp0_hit != 4'h0
    |=> (st.timer_group0_irq_flags_enables[7:4] & $past(events.tgrp0_hit))
        == $past(events.tgrp0_hit))
    else $error("group 0 event lost");
  a_tgrp1_sets: assert property (
    events.tgrp1_hit != 4'h0
    |=> (st.timer_group1_irq_flags_enables[7:4] & $past(events.tgrp1_hit))
        == $past(events.tgrp1_hit))
    else $error("group 1 event lost");
  a_wake_quiet: assert property (
    (event_now != 12'h000 && (event_now & ~flag_now) == 12'h000)
    |=> !wake)
    else $error("wake from a preset flag");
  a_status_full: assert property (
    (bus.rd && bus.addr == OFS_STAT)
    |=> rdata[STAT_FULL_BIT] == $past(stack_full))
    else $error("status full bit wrong");

  c_take_mf: cover property (core.take && st.last_sel == MFIC_SEL_MF0);
  c_blocked_full: cover property (instr_boundary && st.gie && any_req && stack_full);
  c_take_then_return_from_interrupt: cover property (core.take ##[1:20] core.pop);
  c_own_over_mf: cover property (accept && own_req[0] && mf_req[0]);
  c_boundary_wait: cover property (!instr_boundary && st.gie && any_req);

endmodule // mfic_top

`default_nettype wire

// file: testbench/mfic_core_model.sv
// partner model: core stack answering push and pop requests
`timescale 1ns/100ps
`default_nettype none
module mfic_core_model
  import mfic_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic            clock,
  input  wire logic            nrst,
  input  wire mfic_core_t      core,
  output var  logic            stack_full,
  output var  logic [PC_W-1:0] top
);
  logic [PC_W-1:0] mem [DEPTH];
  int              sp;
  // shallow on purpose so a full stack is reached quickly
  assign stack_full = (sp == DEPTH);
  // empty stack shows all ones, never a stale entry
  assign top = (sp > 0) ? mem[sp-1] : '1;
  always @(posedge clock) begin
    if (!nrst) begin
      sp <= 0;
    end else if (core.push && sp < DEPTH) begin
      mem[sp] <= core.push_data;
      sp      <= sp + 1;
    end else if (core.pop && sp > 0) begin
      sp <= sp - 1;
    end
  end
endmodule // mfic_core_model
`default_nettype wire

// file: testbench/multifunction_interrupt_control_test.sv
// testbench: register map, flags, vectoring, stack and wake checks
`timescale 1ns/100ps
`default_nettype none
module multifunction_interrupt_control_test
  import mfic_pkg::*;
;
  // ****
  // stimulus and table
  // ****
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    mfic_events_t      evt;
    logic [DATA_W-1:0] exp;
  } mfic_row_t;
  // off-default vectors catch hard-coded addresses
  localparam logic [PC_W-1:0] V_OWN0 = 13'h0104;
  localparam logic [PC_W-1:0] V_MF0  = 13'h010c;
  logic              clock = 1'b0;
  logic              nrst = 1'b0;
  mfic_bus_t         bus = '0;
  mfic_events_t      events = '0;
  logic              instr_boundary = 1'b1;
  logic [PC_W-1:0]   next_pc = 13'h0123;
  logic              return_from_interrupt = 1'b0;
  logic [DATA_W-1:0] rdata;
  mfic_core_t        core;
  logic              wake;
  logic              stack_full;
  logic [PC_W-1:0]   top;
  int                bad_count = 0;
  int                n_compared = 0;
  int                takes = 0;
  int                wakes = 0;
  int                t0;
  mfic_row_t rows [8] = '{
    '{3'h1, 8'h0f, 12'h008, 8'h8f},
    '{3'h1, 8'h00, 12'h001, 8'h10},
    '{3'h2, 8'h0f, 12'h040, 8'h4f},
    '{3'h2, 8'h00, 12'h020, 8'h20},
    '{3'h3, 8'hff, 12'h200, 8'h33},
    '{3'h3, 8'h00, 12'h100, 8'h10},
    '{3'h0, 8'h00, 12'h400, 8'h10},
    '{3'h5, 8'hff, 12'h000, 8'h00}
  };
  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (core.take === 1'b1) takes++;
    if (wake === 1'b1) wakes++;
  end
  mfic_top #(.VEC_OWN0(V_OWN0), .VEC_MF0(V_MF0)) dut (.clock(clock), .nrst(nrst),
    .bus(bus), .rdata(rdata), .events(events), .instr_boundary(instr_boundary),
    .next_pc(next_pc), .stack_full(stack_full), .return_from_interrupt(return_from_interrupt), .core(core), .wake(wake));
  mfic_core_model #(.DEPTH(2)) core_model (.clock(clock), .nrst(nrst), .core(core),
    .stack_full(stack_full), .top(top));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic hit(input mfic_events_t e);
    @(posedge clock);
    events <= e;
    @(posedge clock);
    events <= '0;
  endtask
  task automatic wait_take(input logic [PC_W-1:0] vec, input logic [PC_W-1:0] pc);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      if (core.take === 1'b1) break;
    end
    chk(core.push, 1'b1);
    chk(core.vector, vec);
    chk(core.push_data, pc);
  endtask
  task automatic no_take;
    t0 = takes;
    repeat (6) @(posedge clock);
    chk(takes, t0);
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 5; a++) rd(a[ADDR_W-1:0], 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      hit(rows[i].evt);
      rd(rows[i].addr, rows[i].exp);
      wr(rows[i].addr, 8'h00);
    end
    chk(wakes, 6);
    chk(takes, 0);
    $display("test table done");
    hit(12'h008);
    wr(OFS_CTRL, 8'h01);
    no_take();
    instr_boundary <= 1'b0;
    wr(OFS_MF0, 8'h88);
    no_take();
    instr_boundary <= 1'b1;
    wait_take(V_MF0, 13'h0123);
    rd(OFS_CTRL, 8'h00);
    rd(OFS_MF0, 8'h88);
    rd(OFS_STAT, 8'h13);
    chk(top, 13'h0123);
    $display("test vectoring done");
    @(posedge clock);
    next_pc <= 13'h0124;
    // own0 flag kept set by the write so both sources compete
    hit(12'h400);
    wr(OFS_CTRL, 8'h13);
    wait_take(V_OWN0, 13'h0124);
    rd(OFS_CTRL, 8'h02);
    chk(stack_full, 1'b1);
    wr(OFS_CTRL, 8'h01);
    no_take();
    @(posedge clock);
    return_from_interrupt <= 1'b1;
    @(posedge clock);
    return_from_interrupt <= 1'b0;
    #1 chk(core.pop, 1'b1);
    @(posedge clock);
    #1 chk(top, 13'h0123);
    wait_take(V_MF0, 13'h0124);
    $display("test stack done");
    wrap_up();
  end
endmodule // multifunction_interrupt_control_test
`default_nettype wire
